// ==== sim/three_level_pwm_gate_logic_test.sv ====
// self-checking bench of the gate controller with a driver model
module three_level_pwm_gate_logic_test;
    import tlpg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // ==================================================================
    // signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    logic        zero_current_sense = 1'b0;
    logic [1:0]  pwm_level_q, skip_mode_select_n_q;
    logic        skip_mode_select_n_oe_q, driver_disable_n_q;
    logic        high_side_gate, low_side_gate;
    int          n_mismatch = 0, tests_run = 0;
    int          hi_n, lo_n, mid_n, both_n, gl_mid, sk_lo, sk_x, gh_n;

    always #25 pclk = ~pclk;

    tlpg_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .zero_current_sense(zero_current_sense),
        .pwm_level_q(pwm_level_q),
        .skip_mode_select_n_q(skip_mode_select_n_q),
        .skip_mode_select_n_oe_q(skip_mode_select_n_oe_q),
        .driver_disable_n_q(driver_disable_n_q));

    tlpg_gate_model drv (.clk(pclk), .pwm_level(pwm_level_q),
        .skip_code(skip_mode_select_n_q),
        .skip_oe(skip_mode_select_n_oe_q),
        .driver_disable_n(driver_disable_n_q), .switch_node_above(1'b1),
        .high_side_gate(high_side_gate), .low_side_gate(low_side_gate));

    // ==================================================================
    // shared tasks
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 32'd2);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] bv(input int b);
        return 32'h1 << b;
    endfunction

    // regime bits latch while disabled, then run
    task automatic mode(input logic [31:0] bits);
        logic [31:0] r;
        logic        e;
        apb(1'b1, TLPG_OFF_CTRL, bits, r, e);
        repeat (3) @(posedge pclk);
        apb(1'b1, TLPG_OFF_CTRL,
            bits | bv(TLPG_BIT_ENABLE) | bv(TLPG_BIT_RUN), r, e);
        repeat (4) @(posedge pclk);
    endtask

    task automatic watch(input int n);
        hi_n = 0; lo_n = 0; mid_n = 0; both_n = 0;
        gl_mid = 0; sk_lo = 0; sk_x = 0; gh_n = 0;
        repeat (n) begin
            @(posedge pclk);
            if (pwm_level_q === TLPG_LVL_HIGH) hi_n++;
            if (pwm_level_q === TLPG_LVL_LOW) lo_n++;
            if (pwm_level_q === TLPG_LVL_MID) mid_n++;
            if (high_side_gate === 1'b1 && low_side_gate === 1'b1) both_n++;
            if (high_side_gate === 1'b1) gh_n++;
            if (pwm_level_q === TLPG_LVL_MID && low_side_gate === 1'b1)
                gl_mid++;
            if (skip_mode_select_n_oe_q === 1'b1 &&
                skip_mode_select_n_q === TLPG_LVL_LOW) sk_lo++;
            if (skip_mode_select_n_oe_q !== 1'b1) sk_x++;
        end
    endtask

    // ==================================================================
    // scenarios
    task automatic t_reset();
        logic [11:0] offs [6] = '{TLPG_OFF_CTRL, TLPG_OFF_PERIOD,
            TLPG_OFF_DUTY, TLPG_OFF_LOWEND, TLPG_OFF_PRESCALE,
            TLPG_OFF_STATUS};
        logic [31:0] exps [6] = '{{26'h0, TLPG_RST_CTRL},
            {16'h0, TLPG_RST_PERIOD}, {16'h0, TLPG_RST_DUTY},
            {16'h0, TLPG_RST_LOWEND}, {16'h0, TLPG_RST_PRESCALE},
            {24'h0, TLPG_LVL_HIGH, TLPG_LVL_LOW, 2'b00, TLPG_ST_OFF}};
        logic [31:0] r;
        logic        e;
        chk({30'h0, pwm_level_q}, {30'h0, TLPG_LVL_LOW});
        chk({31'h0, driver_disable_n_q}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, offs[i], 32'h0, r, e);
            chk(r, exps[i]);
            chk({31'h0, e}, 32'h0);
        end
        apb(1'b0, 12'h018, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b1, TLPG_OFF_PERIOD, 32'd19, r, e);
        apb(1'b1, TLPG_OFF_DUTY, 32'd5, r, e);
        apb(1'b1, TLPG_OFF_LOWEND, 32'd8, r, e);
        apb(1'b0, TLPG_OFF_PERIOD, 32'h0, r, e);
        chk(r, 32'd19);
    endtask

    task automatic t_ccm(input logic [31:0] bits);
        mode(bits);
        watch(60);
        chk(mid_n, 0);
        chk({31'h0, hi_n > 0 && lo_n > 0 && gh_n > 0}, 32'h1);
        chk(both_n, 0);
        chk(sk_lo, 0);
        chk({31'h0, sk_x > 0}, {31'h0, bits[TLPG_BIT_SKIPFLOAT]});
        if (bits[TLPG_BIT_SKIPMID])
            chk({30'h0, skip_mode_select_n_q}, {30'h0, TLPG_LVL_MID});
    endtask

    task automatic t_dcm_int();
        mode(bv(TLPG_BIT_DCM));
        watch(60);
        chk({31'h0, mid_n > 0}, 32'h1);
        chk({31'h0, gl_mid >= 5 && gl_mid < mid_n}, 32'h1);
        chk(sk_lo, 0);
    endtask

    task automatic t_dcm_ext();
        int n;
        mode(bv(TLPG_BIT_EXTERNAL) | bv(TLPG_BIT_DCM));
        watch(40);
        chk(mid_n, 0);
        chk(sk_lo, 40);
        n = 0;
        while (pwm_level_q !== TLPG_LVL_LOW && n < 50) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        chk({30'h0, pwm_level_q}, {30'h0, TLPG_LVL_LOW});
        zero_current_sense <= 1'b1;
        n = 0;
        while (pwm_level_q !== TLPG_LVL_MID && n < 4) begin
            @(posedge pclk);
            n++;
        end
        zero_current_sense <= 1'b0;
        chk({30'h0, pwm_level_q}, {30'h0, TLPG_LVL_MID});
        @(posedge pclk);
        chk({30'h0, high_side_gate, low_side_gate}, 32'h0);
        watch(30);
        chk(sk_lo, 30);
    endtask

    task automatic t_off();
        logic [31:0] r;
        logic        e;
        apb(1'b1, TLPG_OFF_CTRL, 32'h0, r, e);
        repeat (2) @(posedge pclk);
        chk({31'h0, driver_disable_n_q}, 32'h0);
        chk({30'h0, pwm_level_q}, {30'h0, TLPG_LVL_LOW});
        repeat (3) @(posedge pclk);
        chk({30'h0, high_side_gate, low_side_gate}, 32'h0);
    endtask

    // ==================================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ccm(32'h0);
        t_ccm(bv(TLPG_BIT_SKIPFLOAT));
        t_ccm(bv(TLPG_BIT_SKIPMID));
        t_dcm_int();
        t_off();
        t_dcm_ext();
        t_off();
        wrap_up();
    end

    initial begin
        #(5000 * 50);
        n_mismatch++;
        wrap_up();
    end
endmodule

// ==== sim/tlpg_gate_model.sv ====
// behavioural model of the half-bridge gate driver beyond the pins
module tlpg_gate_model
    import tlpg_pkg::*;
#(
    // local timing clock counts
    parameter int NOL_CYC      = 2,
    parameter int DEBOUNCE_CYC = 2,
    parameter int BLANK_CYC    = 3
)(
    // timing clock
    input  wire logic       clk,
    // controller pins as level codes
    input  wire logic [1:0] pwm_level,
    input  wire logic [1:0] skip_code,
    input  wire logic       skip_oe,
    input  wire logic       driver_disable_n,
    // switch node above zero-current threshold
    input  wire logic       switch_node_above,
    // gate commands
    output logic            high_side_gate,
    output logic            low_side_gate
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] skip_pin;
    logic       external;
    logic [1:0] prev = TLPG_LVL_LOW;
    int         cnt = 0;

    // undriven pin pulled up; mid acts as high
    assign skip_pin = skip_oe ? skip_code : TLPG_LVL_HIGH;
    assign external = (skip_pin == TLPG_LVL_LOW);

    always @(posedge clk) begin
        prev <= pwm_level;
        if (driver_disable_n !== 1'b1) begin
            high_side_gate <= 1'b0;
            low_side_gate  <= 1'b0;
            cnt            <= 0;
        end else if (pwm_level != prev) begin
            high_side_gate <= 1'b0;
            low_side_gate  <= 1'b0;
            cnt            <= 0;
        end else begin
            cnt <= cnt + 1;
            case (pwm_level)
                TLPG_LVL_HIGH: begin
                    if (cnt >= NOL_CYC) begin
                        high_side_gate <= 1'b1;
                    end
                end
                TLPG_LVL_LOW: begin
                    if (cnt >= NOL_CYC) begin
                        low_side_gate <= 1'b1;
                    end
                end
                default: begin
                    // external regime: mid keeps both gates off
                    if (!external && cnt == NOL_CYC) begin
                        low_side_gate <= 1'b1;
                    end else if (!external && switch_node_above &&
                        cnt >= NOL_CYC + DEBOUNCE_CYC + BLANK_CYC) begin
                        low_side_gate <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule

// ==== src/tlpg_ctrl.sv ====
// controller that drives the three-level pwm gate driver pins
module tlpg_ctrl
    import tlpg_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // converter sensing
    input  wire logic        zero_current_sense,
    // driver pins
    output logic      [1:0]  pwm_level_q,
    output logic      [1:0]  skip_mode_select_n_q,
    output logic             skip_mode_select_n_oe_q,
    output logic             driver_disable_n_q
);
    // ==================================================================
    // helpers
    function automatic logic reached(input logic [15:0] phase,
                                     input logic [15:0] limit);
        reached = phase >= limit;
    endfunction

    function automatic logic [1:0] lvl_of(input tlpg_state_t st);
        case (st)
            TLPG_ST_HIGH: lvl_of = TLPG_LVL_HIGH;
            TLPG_ST_MID:  lvl_of = TLPG_LVL_MID;
            default:      lvl_of = TLPG_LVL_LOW;
        endcase
    endfunction

    // ==================================================================
    // registers and timebase
    logic [5:0]  ctrl_q;
    logic [15:0] period_q, duty_q, lowend_q, prescale_q, phase_q;
    logic [31:0] status;
    logic        tick, cycle_start;
    tlpg_state_t state_q, state_d;
    logic        ext_q, ext_d, dcm_q, dcm_d, float_q, float_d;
    logic        smid_q, smid_d, go, lowend_hit;
    logic [15:0] dcm_cnt_q, dcm_cnt_d;
    logic [1:0]  skip_d, pwm_d;
    logic        skip_oe_d, dis_n_d;

    assign status = {dcm_cnt_q, 8'h0, skip_mode_select_n_q, pwm_level_q,
                     dcm_q, ext_q, state_q};

    tlpg_regs u_regs (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .ctrl_q     (ctrl_q),
        .period_q   (period_q),
        .duty_q     (duty_q),
        .lowend_q   (lowend_q),
        .prescale_q (prescale_q),
        .status     (status)
    );

    tlpg_timebase u_tb (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         (go),
        .prescale    (prescale_q),
        .period      (period_q),
        .tick        (tick),
        .cycle_start (cycle_start),
        .phase_q     (phase_q)
    );

    // clearing enable stops the sequencer in the same cycle
    assign go = driver_disable_n_q && ctrl_q[TLPG_BIT_ENABLE]
                && ctrl_q[TLPG_BIT_RUN];
    assign lowend_hit = reached(phase_q, lowend_q);

    // ==================================================================
    // regime latch: only changes while the driver is disabled
    always_comb begin
        ext_d   = ext_q;
        dcm_d   = dcm_q;
        float_d = float_q;
        smid_d  = smid_q;
        if (!ctrl_q[TLPG_BIT_ENABLE]) begin
            ext_d   = ctrl_q[TLPG_BIT_EXTERNAL];
            dcm_d   = ctrl_q[TLPG_BIT_DCM];
            float_d = ctrl_q[TLPG_BIT_SKIPFLOAT];
            smid_d  = ctrl_q[TLPG_BIT_SKIPMID];
        end
        // a regime change adds no disabled cycle: ext_d equals ext_q whenever enable is set
        dis_n_d   = ctrl_q[TLPG_BIT_ENABLE] && (ext_d == ext_q);
        skip_oe_d = 1'b1;
        if (ext_d) begin
            skip_d = TLPG_LVL_LOW;
        end else if (smid_d) begin
            skip_d = TLPG_LVL_MID;
        end else begin
            skip_d    = TLPG_LVL_HIGH;
            skip_oe_d = !float_d;
        end
    end

    // ==================================================================
    // pwm sequencer
    always_comb begin
        state_d   = state_q;
        dcm_cnt_d = dcm_cnt_q;
        case (state_q)
            TLPG_ST_OFF: begin
                if (go && cycle_start) begin
                    state_d = TLPG_ST_HIGH;
                end
            end
            TLPG_ST_HIGH: begin
                if (!go) begin
                    state_d = TLPG_ST_OFF;
                end else if (tick && reached(phase_q, duty_q)) begin
                    state_d = TLPG_ST_LOW;
                end
            end
            TLPG_ST_LOW: begin
                if (!go) begin
                    state_d = TLPG_ST_OFF;
                end else if (cycle_start) begin
                    state_d = TLPG_ST_HIGH;
                end else if (dcm_q && !ext_q
                             && reached(phase_q, lowend_q)) begin
                    state_d   = TLPG_ST_MID;
                    dcm_cnt_d = dcm_cnt_q + 16'h1;
                end else if (dcm_q && ext_q && zero_current_sense) begin
                    state_d   = TLPG_ST_MID;
                    dcm_cnt_d = dcm_cnt_q + 16'h1;
                end
            end
            default: begin
                if (!go) begin
                    state_d = TLPG_ST_OFF;
                end else if (cycle_start) begin
                    state_d = TLPG_ST_HIGH;
                end
            end
        endcase
        // continuous conduction never reaches mid
        pwm_d = lvl_of(state_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q                 <= TLPG_ST_OFF;
            dcm_cnt_q               <= 16'h0;
            ext_q                   <= 1'b0;
            dcm_q                   <= 1'b0;
            float_q                 <= 1'b0;
            smid_q                  <= 1'b0;
            pwm_level_q             <= TLPG_LVL_LOW;
            skip_mode_select_n_q    <= TLPG_LVL_HIGH;
            skip_mode_select_n_oe_q <= 1'b0;
            driver_disable_n_q      <= 1'b0;
        end else begin
            state_q                 <= state_d;
            dcm_cnt_q               <= dcm_cnt_d;
            ext_q                   <= ext_d;
            dcm_q                   <= dcm_d;
            float_q                 <= float_d;
            smid_q                  <= smid_d;
            pwm_level_q             <= pwm_d;
            skip_mode_select_n_q    <= skip_d;
            skip_mode_select_n_oe_q <= skip_oe_d;
            driver_disable_n_q      <= dis_n_d;
        end
    end

    // ==================================================================
    // checks
    ccm_no_mid_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !dcm_q |-> pwm_level_q != TLPG_LVL_MID)
        else $error("mid level used in continuous conduction");

    int_skip_high_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (driver_disable_n_q && !ext_q) |->
        skip_mode_select_n_q != TLPG_LVL_LOW)
        else $error("skip select low in internal detection");

    ext_skip_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (driver_disable_n_q && ext_q) |->
        (skip_mode_select_n_q == TLPG_LVL_LOW && skip_mode_select_n_oe_q))
        else $error("skip select not held low in external detection");

    regime_stable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (driver_disable_n_q && $past(driver_disable_n_q)) |->
        $stable(ext_q) && $stable(skip_mode_select_n_q))
        else $error("regime changed while driver enabled");

    ext_zero_mid_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == TLPG_ST_LOW && go && dcm_q && ext_q
         && zero_current_sense && !cycle_start)
        |=> pwm_level_q == TLPG_LVL_MID)
        else $error("zero current sensed but pwm not mid");

    int_dcm_mid_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == TLPG_ST_LOW && go && dcm_q && !ext_q
         && reached(phase_q, lowend_q) && !cycle_start)
        |=> pwm_level_q == TLPG_LVL_MID)
        else $error("internal detection did not enter mid");

    // ==================================================================
    // sequence checks
    mid_from_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pwm_level_q == TLPG_LVL_MID && $past(pwm_level_q) != TLPG_LVL_MID)
        |-> $past(pwm_level_q) == TLPG_LVL_LOW)
        else $error("mid level entered from other than low");

    int_mid_cause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dcm_q && !ext_q && pwm_level_q == TLPG_LVL_MID
         && $past(pwm_level_q) == TLPG_LVL_LOW) |-> $past(lowend_hit))
        else $error("internal detection left low before low end");

    ext_mid_cause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dcm_q && ext_q && pwm_level_q == TLPG_LVL_MID
         && $past(pwm_level_q) == TLPG_LVL_LOW)
        |-> $past(zero_current_sense))
        else $error("external detection entered mid without zero current");

    ext_wait_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == TLPG_ST_LOW && go && dcm_q && ext_q
         && !zero_current_sense && !cycle_start)
        |=> pwm_level_q == TLPG_LVL_LOW)
        else $error("external detection left low without zero current");

    mid_holds_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pwm_level_q == TLPG_LVL_MID && go && !cycle_start)
        |=> pwm_level_q == TLPG_LVL_MID)
        else $error("mid level left before period start");

    mid_count_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pwm_level_q == TLPG_LVL_MID && $past(pwm_level_q) == TLPG_LVL_LOW)
        |-> dcm_cnt_q == $past(dcm_cnt_q) + 16'h1)
        else $error("mid entry not counted");

    high_on_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pwm_level_q == TLPG_LVL_HIGH && $past(pwm_level_q) != TLPG_LVL_HIGH)
        |-> $past(cycle_start))
        else $error("pwm raised outside period start");

    duty_end_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == TLPG_ST_HIGH && go && tick
         && reached(phase_q, duty_q))
        |=> pwm_level_q == TLPG_LVL_LOW)
        else $error("pwm not low after duty end");

    idle_pwm_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !driver_disable_n_q |-> pwm_level_q == TLPG_LVL_LOW)
        else $error("pwm not low while driver disabled");

    skip_oe_stable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (driver_disable_n_q && $past(driver_disable_n_q)) |->
        $stable(skip_mode_select_n_oe_q))
        else $error("skip pin drive changed while driver enabled");
endmodule

// ==== src/tlpg_pkg.sv ====
// package of constants for the three-level pwm gate controller
package tlpg_pkg;
    // ==================================================================
    // register offsets
    localparam logic [11:0] TLPG_OFF_CTRL     = 12'h000;
    localparam logic [11:0] TLPG_OFF_PERIOD   = 12'h004;
    localparam logic [11:0] TLPG_OFF_DUTY     = 12'h008;
    localparam logic [11:0] TLPG_OFF_LOWEND   = 12'h00c;
    localparam logic [11:0] TLPG_OFF_PRESCALE = 12'h010;
    localparam logic [11:0] TLPG_OFF_STATUS   = 12'h014;
    // ==================================================================
    // control fields
    localparam int TLPG_CTRL_W        = 6;
    localparam int TLPG_BIT_ENABLE    = 0;
    localparam int TLPG_BIT_EXTERNAL  = 1;
    localparam int TLPG_BIT_SKIPFLOAT = 2;
    localparam int TLPG_BIT_SKIPMID   = 3;
    localparam int TLPG_BIT_DCM       = 4;
    localparam int TLPG_BIT_RUN       = 5;
    // ==================================================================
    // reset values
    localparam logic [5:0]  TLPG_RST_CTRL     = 6'h00;
    localparam logic [15:0] TLPG_RST_PERIOD   = 16'h0063;
    localparam logic [15:0] TLPG_RST_DUTY     = 16'h0020;
    localparam logic [15:0] TLPG_RST_LOWEND   = 16'h0040;
    localparam logic [15:0] TLPG_RST_PRESCALE = 16'h0000;
    // ==================================================================
    // three-level pin codes
    localparam logic [1:0] TLPG_LVL_LOW  = 2'h0;
    localparam logic [1:0] TLPG_LVL_MID  = 2'h1;
    localparam logic [1:0] TLPG_LVL_HIGH = 2'h2;
    // ==================================================================
    // gate sequence states, gray along off-high-low-mid; mid-high flips both bits
    typedef enum logic [1:0] {
        TLPG_ST_OFF  = 2'h0,
        TLPG_ST_HIGH = 2'h1,
        TLPG_ST_LOW  = 2'h3,
        TLPG_ST_MID  = 2'h2
    } tlpg_state_t;
endpackage

// ==== src/tlpg_regs.sv ====
// apb register file of the three-level pwm gate controller
module tlpg_regs
    import tlpg_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // register contents
    output logic      [5:0]  ctrl_q,
    output logic      [15:0] period_q,
    output logic      [15:0] duty_q,
    output logic      [15:0] lowend_q,
    output logic      [15:0] prescale_q,
    input  wire logic [31:0] status
);
    logic [5:0]  ctrl_d;
    logic [15:0] period_d, duty_d, lowend_d, prescale_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d, hit, done;

    // one wait state: answer registered on the first access cycle
    always_comb begin
        ctrl_d     = ctrl_q;
        period_d   = period_q;
        duty_d     = duty_q;
        lowend_d   = lowend_q;
        prescale_d = prescale_q;
        prdata_d   = prdata;
        hit        = 1'b1;
        done       = psel && penable && pready;
        pready_d   = psel && penable && !pready;
        if (paddr == TLPG_OFF_CTRL) begin
            prdata_d = {26'h0, ctrl_q};
        end else if (paddr == TLPG_OFF_PERIOD) begin
            prdata_d = {16'h0, period_q};
        end else if (paddr == TLPG_OFF_DUTY) begin
            prdata_d = {16'h0, duty_q};
        end else if (paddr == TLPG_OFF_LOWEND) begin
            prdata_d = {16'h0, lowend_q};
        end else if (paddr == TLPG_OFF_PRESCALE) begin
            prdata_d = {16'h0, prescale_q};
        end else if (paddr == TLPG_OFF_STATUS) begin
            prdata_d = status;
        end else begin
            prdata_d = 32'h0;
            hit      = 1'b0;
        end
        if (!pready_d) begin
            prdata_d = prdata;
        end
        pslverr_d = pready_d && !hit;
        if (done && pwrite && !pslverr) begin
            if (paddr == TLPG_OFF_CTRL) begin
                ctrl_d = pwdata[5:0];
            end else if (paddr == TLPG_OFF_PERIOD) begin
                period_d = pwdata[15:0];
            end else if (paddr == TLPG_OFF_DUTY) begin
                duty_d = pwdata[15:0];
            end else if (paddr == TLPG_OFF_LOWEND) begin
                lowend_d = pwdata[15:0];
            end else if (paddr == TLPG_OFF_PRESCALE) begin
                prescale_d = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= TLPG_RST_CTRL;
            period_q   <= TLPG_RST_PERIOD;
            duty_q     <= TLPG_RST_DUTY;
            lowend_q   <= TLPG_RST_LOWEND;
            prescale_q <= TLPG_RST_PRESCALE;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            period_q   <= period_d;
            duty_q     <= duty_d;
            lowend_q   <= lowend_d;
            prescale_q <= prescale_d;
            prdata     <= prdata_d;
            pready     <= pready_d;
            pslverr    <= pslverr_d;
        end
    end
endmodule

// ==== src/tlpg_timebase.sv ====
// prescaled switching-period timebase
module tlpg_timebase
    import tlpg_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // setup
    input  wire logic        run,
    input  wire logic [15:0] prescale,
    input  wire logic [15:0] period,
    // timing out
    output logic             tick,
    output logic             cycle_start,
    output logic      [15:0] phase_q
);
    logic [15:0] div_q, div_d, phase_d;
    logic        tick_d, start_d;

    always_comb begin
        div_d   = div_q;
        phase_d = phase_q;
        tick_d  = 1'b0;
        start_d = 1'b0;
        if (!run) begin
            div_d   = 16'h0;
            phase_d = period;
        end else if (div_q >= prescale) begin
            div_d  = 16'h0;
            tick_d = 1'b1;
            if (phase_q >= period) begin
                phase_d = 16'h0;
                start_d = 1'b1;
            end else begin
                phase_d = phase_q + 16'h1;
            end
        end else begin
            div_d = div_q + 16'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q       <= 16'h0;
            phase_q     <= 16'h0;
            tick        <= 1'b0;
            cycle_start <= 1'b0;
        end else begin
            div_q       <= div_d;
            phase_q     <= phase_d;
            tick        <= tick_d;
            cycle_start <= start_d;
        end
    end
endmodule
